// file: mmwc_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmwc_regs.svh"
module mmwc_decoder #(
   parameter logic [15:0] PART_ID  = 16'h00A5, // arbitrary value
   parameter logic [15:0] CLASS_ID = 16'h005A, // arbitrary value
   parameter logic [15:0] REV_ID   = 16'h0003  // arbitrary value
) (
   input  wire logic              sys_clk_i,      // 100 MHz clock
   input  wire logic              reset_n_i,      // async reset
   input  wire mmwc_pkg::mmwc_req_t cpu_i,        // cpu/dma request
   input  wire logic              periph_ready_i, // peripheral ready
   input  wire logic [31:0]       mem_rdata_i,    // memory side data
   input  wire logic              unlock_i,       // unlock instruction
   input  wire logic              lock_i,         // lock instruction
   input  wire logic              sec_ok_i,       // security permission
   input  wire logic              order_en_i,     // ordering load enable
   input  wire logic              order_set_i,    // ordering value
   input  wire mmwc_pkg::mmwc_flwait_t fl_wait_i, // flash wait program
   input  wire logic              fl_wait_wr_i,   // flash wait strobe
   output logic                   done_o,         // access complete
   output logic [31:0]            rdata_o,        // read data
   output mmwc_pkg::mmwc_req_t    mem_o,          // forwarded access
   output logic [3:0]             region_o,       // decoded region
   output logic [2:0]             sector_o,       // flash sector
   output logic                   wr_blocked_o,   // write discarded
   output logic                   unlocked_o      // unlock state
);
   mmwc_pkg::mmwc_state_t  state;
   mmwc_pkg::mmwc_region_t cur_rg;
   mmwc_pkg::mmwc_req_t    cur;
   mmwc_pkg::mmwc_flwait_t flw;
   logic [4:0]  wcnt;
   logic        ready_ext;
   logic        order_prot;
   logic        last_wr_prot;
   logic        last_wr_f1;
   logic        blocked;
   logic [31:0] devcnf;
   logic        rdy_s1, rdy_s2;
   logic [21:0] pl;

   mmwc_pkg::mmwc_region_t next_rg;
   logic [4:0]  next_wait;
   logic        next_prot_w;
   logic        next_ro;
   logic        in_f0;
   logic        next_align;

   // ready comes from peripheral logic outside this clock domain view
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdy_s1 <= 1'b0;
         rdy_s2 <= 1'b0;
      end else begin
         rdy_s1 <= periph_ready_i;
         rdy_s2 <= rdy_s1;
      end
   end

   always_comb begin
      pl        = cpu_i.addr;
      next_rg   = mmwc_pkg::MMWC_RG_RES;
      next_wait = 5'h00;
      next_prot_w = 1'b0;
      next_ro   = 1'b0;
      in_f0     = (pl >= `MMWC_F0_LO) && (pl <= `MMWC_F0_HI);
      if (pl <= `MMWC_M01_HI ||
          (pl >= `MMWC_LRAM_LO && pl <= `MMWC_LRAM_HI)) begin
         next_rg = mmwc_pkg::MMWC_RG_RAM;
      end else if (pl == `MMWC_CLASS_IDENTIFIER_ADR || pl == `MMWC_REVISION_IDENTIFIER_ADR ||
                   pl == `MMWC_PART_IDENTIFIER_ADR) begin
         next_rg = mmwc_pkg::MMWC_RG_ID;
         next_ro = 1'b1;
      end else if (pl >= `MMWC_DEVCNF_LO && pl <= `MMWC_DEVCNF_HI) begin
         next_rg = mmwc_pkg::MMWC_RG_ID;
         next_prot_w = 1'b1;
      end else if (in_f0) begin
         next_rg = mmwc_pkg::MMWC_RG_F0;
         if ((pl <= `MMWC_EMU_HI) ||
             (pl >= `MMWC_FLREG_LO && pl <= `MMWC_CSM_HI) ||
             (pl >= `MMWC_PIEV_LO && pl <= `MMWC_PIEV_HI) ||
             (pl >= `MMWC_DMA_LO && pl <= `MMWC_DMA_HI))
            next_prot_w = 1'b1;
         if (pl >= `MMWC_ADCR_LO && pl <= `MMWC_ADCR_HI)
            next_ro = 1'b1;
      end else if (pl >= `MMWC_F3_LO && pl < `MMWC_F1_LO) begin
         next_rg = mmwc_pkg::MMWC_RG_F3;
         next_wait = cpu_i.wr ? 5'h00 : `MMWC_PER_RD_WAIT;
      end else if (pl >= `MMWC_F1_LO && pl < `MMWC_F2_LO) begin
         next_rg = mmwc_pkg::MMWC_RG_F1;
         next_wait = cpu_i.wr ? 5'h00 : `MMWC_PER_RD_WAIT;
      end else if (pl >= `MMWC_F2_LO && pl <= `MMWC_F2_HI) begin
         next_rg = mmwc_pkg::MMWC_RG_F2;
         next_wait = cpu_i.wr ? 5'h00 : `MMWC_PER_RD_WAIT;
         if (pl >= `MMWC_SYSC_LO && pl <= `MMWC_SYSC_HI)
            next_prot_w = 1'b1;
      end else if (pl >= `MMWC_OTP_LO && pl <= `MMWC_OTP_HI) begin
         next_rg = mmwc_pkg::MMWC_RG_OTP;
         next_wait = {1'b0, flw.otp};
      end else if (pl >= `MMWC_PWD_LO && pl <= `MMWC_FLASH_HI) begin
         next_rg = mmwc_pkg::MMWC_RG_PWD;
         next_wait = `MMWC_PWD_WAIT;
      end else if (pl >= `MMWC_FLASH_LO && pl < `MMWC_PWD_LO) begin
         next_rg = mmwc_pkg::MMWC_RG_FLASH;
         // sequential fetch in same line counts as paged
         next_wait = (cur.addr[21:2] == pl[21:2]) ? {1'b0, flw.paged}
                                                  : {1'b0, flw.random};
      end else if (pl >= `MMWC_BROM_LO) begin
         next_rg = mmwc_pkg::MMWC_RG_ROM;
      end
   end

   // flash controls need both unlock and security clearance
   always_comb begin
      blocked = cpu_i.wr && ((next_prot_w && !unlocked_o) || next_ro ||
                next_rg == mmwc_pkg::MMWC_RG_RES);
      if (cpu_i.wr && in_f0 && pl >= `MMWC_FLREG_LO && pl <= `MMWC_FLREG_HI
          && !sec_ok_i)
         blocked = 1'b1;
      next_align = (order_prot && last_wr_prot && !cpu_i.wr &&
                    (next_rg == mmwc_pkg::MMWC_RG_F1 ||
                     next_rg == mmwc_pkg::MMWC_RG_F2 ||
                     next_rg == mmwc_pkg::MMWC_RG_F3)) ||
                   (last_wr_f1 && cpu_i.wr &&
                    next_rg == mmwc_pkg::MMWC_RG_F1);
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         unlocked_o <= 1'b0;
      else if (unlock_i)
         unlocked_o <= 1'b1;
      else if (lock_i)
         unlocked_o <= 1'b0;
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         order_prot <= 1'b1;
      else if (order_en_i)
         order_prot <= order_set_i;
   end

   // random below its floor goes to the floor, else up to paged; otp to its floor
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         flw.paged  <= 4'hF;
         flw.random <= 4'hF;
         flw.otp    <= 4'hF;
      end else if (fl_wait_wr_i && unlocked_o && sec_ok_i) begin
         flw.paged  <= fl_wait_i.paged;
         flw.random <= (fl_wait_i.random < `MMWC_RND_MIN) ? `MMWC_RND_MIN :
                       (fl_wait_i.random < fl_wait_i.paged) ?
                       fl_wait_i.paged : fl_wait_i.random;
         flw.otp    <= (fl_wait_i.otp < `MMWC_OTP_MIN) ? `MMWC_OTP_MIN
                                                       : fl_wait_i.otp;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state        <= mmwc_pkg::MMWC_ST_IDLE;
         cur          <= '0;
         cur_rg       <= mmwc_pkg::MMWC_RG_RES;
         wcnt         <= 5'h00;
         ready_ext    <= 1'b0;
         done_o       <= 1'b0;
         mem_o        <= '0;
         region_o     <= 4'h0;
         sector_o     <= 3'h0;
         wr_blocked_o <= 1'b0;
         last_wr_prot <= 1'b0;
         last_wr_f1   <= 1'b0;
      end else begin
         done_o <= 1'b0;
         mem_o.req <= 1'b0;
         case (state)
            mmwc_pkg::MMWC_ST_IDLE: begin
               if (cpu_i.req) begin
                  cur       <= cpu_i;
                  cur.wide  <= cpu_i.wide && in_f0;
                  cur_rg    <= next_rg;
                  region_o  <= next_rg;
                  wcnt      <= next_wait;
                  ready_ext <= next_rg == mmwc_pkg::MMWC_RG_F1 ||
                               next_rg == mmwc_pkg::MMWC_RG_F3;
                  wr_blocked_o <= blocked;
                  if (next_rg == mmwc_pkg::MMWC_RG_FLASH)
                     sector_o <= 3'(22'(pl - `MMWC_FLASH_LO)
                                 >> `MMWC_SECT_SHIFT);
                  state <= next_align ? mmwc_pkg::MMWC_ST_ALIGN
                                      : mmwc_pkg::MMWC_ST_WAIT;
               end else begin
                  // an idle cycle ends any back-to-back pair
                  last_wr_prot <= 1'b0;
                  last_wr_f1   <= 1'b0;
               end
            end
            mmwc_pkg::MMWC_ST_ALIGN: begin
               state <= mmwc_pkg::MMWC_ST_WAIT;
            end
            mmwc_pkg::MMWC_ST_WAIT: begin
               if (wcnt != 5'h00) begin
                  wcnt <= wcnt - 5'h01;
               end else if (!ready_ext || rdy_s2) begin
                  state <= mmwc_pkg::MMWC_ST_DONE;
                  done_o <= 1'b1;
                  mem_o <= cur;
                  mem_o.req <= !wr_blocked_o && cur_rg != mmwc_pkg::MMWC_RG_ID
                               && cur_rg != mmwc_pkg::MMWC_RG_RES;
                  last_wr_prot <= cur.wr && (cur_rg == mmwc_pkg::MMWC_RG_F1 ||
                                  cur_rg == mmwc_pkg::MMWC_RG_F2 ||
                                  cur_rg == mmwc_pkg::MMWC_RG_F3);
                  last_wr_f1 <= cur.wr && cur_rg == mmwc_pkg::MMWC_RG_F1;
               end
            end
            mmwc_pkg::MMWC_ST_DONE: begin
               state <= mmwc_pkg::MMWC_ST_IDLE;
            end
            default: state <= mmwc_pkg::MMWC_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         devcnf <= `MMWC_CNF_RESET;
      else if (state == mmwc_pkg::MMWC_ST_WAIT && wcnt == 5'h00 &&
               cur.wr && !wr_blocked_o && cur_rg == mmwc_pkg::MMWC_RG_ID)
         devcnf <= cur.addr[0] ? {cur.wdata[15:0], devcnf[15:0]}
                               : (cur.wide ? cur.wdata
                                  : {devcnf[31:16], cur.wdata[15:0]});
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         rdata_o <= 32'h0000_0000;
      else if (state == mmwc_pkg::MMWC_ST_WAIT && !cur.wr) begin
         case (cur_rg)
            mmwc_pkg::MMWC_RG_ID: begin
               if (cur.addr == `MMWC_PART_IDENTIFIER_ADR)
                  rdata_o <= {16'h0000, PART_ID};
               else if (cur.addr == `MMWC_CLASS_IDENTIFIER_ADR)
                  rdata_o <= {16'h0000, CLASS_ID};
               else if (cur.addr == `MMWC_REVISION_IDENTIFIER_ADR)
                  rdata_o <= {16'h0000, REV_ID};
               else if (cur.addr == `MMWC_DEVCNF_HI)
                  rdata_o <= {16'h0000, devcnf[31:16]};
               else
                  rdata_o <= cur.wide ? devcnf : {16'h0000, devcnf[15:0]};
            end
            mmwc_pkg::MMWC_RG_RES: rdata_o <= 32'h0000_0000;
            default: rdata_o <= cur.wide ? mem_rdata_i
                                         : {16'h0000, mem_rdata_i[15:0]};
         endcase
      end
   end

   chk_pwd_wait_fixed: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      (state == mmwc_pkg::MMWC_ST_IDLE && cpu_i.req && !next_align &&
       next_rg == mmwc_pkg::MMWC_RG_PWD) |-> ##18 done_o)
      else $error("password read did not take sixteen waits");

   chk_lock_blocks_wr: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      (done_o && mem_o.wr && !unlocked_o && !unlock_i && !$past(unlocked_o))
      |-> !(mem_o.req && (region_o == mmwc_pkg::MMWC_RG_F2) &&
            mem_o.addr >= `MMWC_SYSC_LO && mem_o.addr <= `MMWC_SYSC_HI))
      else $error("locked protected write reached memory");

   chk_ro_adc_write: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      (done_o && mem_o.wr && mem_o.addr >= `MMWC_ADCR_LO &&
       mem_o.addr <= `MMWC_ADCR_HI) |-> !mem_o.req)
      else $error("converter result write forwarded");

   chk_rnd_ge_paged: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      flw.random >= flw.paged && flw.random >= `MMWC_RND_MIN)
      else $error("random wait below paged or minimum");

   chk_otp_min_wait: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i) flw.otp >= `MMWC_OTP_MIN)
      else $error("otp wait below one");

   chk_order_reset_on: assert property (@(posedge sys_clk_i)
      $rose(reset_n_i) |-> order_prot)
      else $error("ordering protection off after reset");

   sequence s_f2_read_start;
      state == mmwc_pkg::MMWC_ST_IDLE && cpu_i.req && !cpu_i.wr &&
      !next_align && next_rg == mmwc_pkg::MMWC_RG_F2;
   endsequence

   sequence s_f2_write_start;
      state == mmwc_pkg::MMWC_ST_IDLE && cpu_i.req && cpu_i.wr &&
      !next_align && next_rg == mmwc_pkg::MMWC_RG_F2;
   endsequence

   chk_f2_read_fixed: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i) s_f2_read_start |-> !done_o [*4] ##1 done_o)
      else $error("frame 2 read not two waits");

   chk_f2_write_zero: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i) s_f2_write_start |-> !done_o [*2] ##1 done_o)
      else $error("frame 2 write not zero waits");

   chk_f1_wr_stall: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      (state == mmwc_pkg::MMWC_ST_IDLE && cpu_i.req && cpu_i.wr &&
       last_wr_f1 && next_rg == mmwc_pkg::MMWC_RG_F1)
      |=> state == mmwc_pkg::MMWC_ST_ALIGN)
      else $error("back to back frame 1 write not stalled");

   chk_ram_zero_wait: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      (state == mmwc_pkg::MMWC_ST_IDLE && cpu_i.req &&
       next_rg == mmwc_pkg::MMWC_RG_RAM && !next_align) |-> ##2 done_o)
      else $error("ram access not zero wait");

   chk_ready_extends: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      (state == mmwc_pkg::MMWC_ST_WAIT && wcnt == 5'h00 && ready_ext &&
       !rdy_s2) |=> !done_o)
      else $error("ready low but access completed");

   chk_align_order: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      (state == mmwc_pkg::MMWC_ST_IDLE && cpu_i.req && !cpu_i.wr &&
       order_prot && last_wr_prot && next_rg == mmwc_pkg::MMWC_RG_F2)
      |=> state == mmwc_pkg::MMWC_ST_ALIGN)
      else $error("read after protected write not aligned");

   chk_unlock_state: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i) unlock_i |=> unlocked_o)
      else $error("unlock instruction not taken");

   chk_lock_state: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i) lock_i && !unlock_i |=> !unlocked_o)
      else $error("lock instruction not taken");

   chk_res_read_zero: assert property (@(posedge sys_clk_i)
      disable iff (!reset_n_i)
      (done_o && !mem_o.wr && region_o == mmwc_pkg::MMWC_RG_RES)
      |-> rdata_o == 32'h0000_0000)
      else $error("reserved read returned data");
endmodule
`default_nettype wire

// file: mmwc_regs.svh
// What this block does
// - flash decoded as eight 16K-word sectors upward
// - protected write-then-read kept in program order
// - ordering protection programmable, enabled after reset
// - single access RAM completes with zero waits
// - frame 1 write zero, read two, ready-extended
// - back-to-back frame 1 writes stall one cycle
// - frame 2 write zero, read two, fixed
// - frame 3 write zero, read two, ready-extended
// - one-time area waits programmable, minimum one
// - flash paged/random waits, random never below paged unless written as zero
// - password reads always take sixteen waits
// - frame 0 accepts 16 and 32 bit accesses
// - protected writes ignored until unlock, lock blocks
// - flash registers also need security permission
// - peripheral accesses routed by frame
// - frame 0 flash, security, DMA ranges protected
// - frame 2 system control range protected
// - converter results read-only, zero wait, unprotected
// - identification registers, configuration protected
`ifndef MMWC_REGS_SVH
`define MMWC_REGS_SVH
`define MMWC_FLASH_LO      22'h3D8000
`define MMWC_FLASH_HI      22'h3F7FFF
`define MMWC_SECT_SHIFT    14
`define MMWC_PWD_LO        22'h3F7FF8
`define MMWC_OTP_LO        22'h3D7800
`define MMWC_OTP_HI        22'h3D7BFF
`define MMWC_PART_IDENTIFIER_ADR    22'h3D7E80
`define MMWC_M01_HI        22'h0007FF
`define MMWC_F0_LO         22'h000800
`define MMWC_F0_HI         22'h0013FF
`define MMWC_DEVCNF_LO     22'h000880
`define MMWC_DEVCNF_HI     22'h000881
`define MMWC_CLASS_IDENTIFIER_ADR   22'h000882
`define MMWC_REVISION_IDENTIFIER_ADR     22'h000883
`define MMWC_EMU_HI        22'h000987
`define MMWC_FLREG_LO      22'h000A80
`define MMWC_FLREG_HI      22'h000ADF
`define MMWC_CSM_LO        22'h000AE0
`define MMWC_CSM_HI        22'h000AEF
`define MMWC_ADCR_LO       22'h000B00
`define MMWC_ADCR_HI       22'h000B0F
`define MMWC_PIEV_LO       22'h000D00
`define MMWC_PIEV_HI       22'h000DFF
`define MMWC_DMA_LO        22'h001000
`define MMWC_DMA_HI        22'h0011FF
`define MMWC_F3_LO         22'h005000
`define MMWC_F1_LO         22'h006000
`define MMWC_F2_LO         22'h007000
`define MMWC_F2_HI         22'h007FFF
`define MMWC_SYSC_LO       22'h007010
`define MMWC_SYSC_HI       22'h00702F
`define MMWC_LRAM_LO       22'h008000
`define MMWC_LRAM_HI       22'h013FFF
`define MMWC_BROM_LO       22'h3F8000
`define MMWC_PER_RD_WAIT   5'h02
`define MMWC_PWD_WAIT      5'h10
`define MMWC_OTP_MIN       4'h1
`define MMWC_RND_MIN       4'h1
`define MMWC_CNF_RESET     32'h0000_0000
`endif

// file: mmwc_pkg.sv
`default_nettype none
package mmwc_pkg;
   typedef enum logic [3:0] {
      MMWC_RG_RES   = 4'h0,
      MMWC_RG_RAM   = 4'h1,
      MMWC_RG_F0    = 4'h2,
      MMWC_RG_F1    = 4'h3,
      MMWC_RG_F2    = 4'h4,
      MMWC_RG_F3    = 4'h5,
      MMWC_RG_FLASH = 4'h6,
      MMWC_RG_PWD   = 4'h7,
      MMWC_RG_OTP   = 4'h8,
      MMWC_RG_ROM   = 4'h9,
      MMWC_RG_ID    = 4'hA
   } mmwc_region_t;

   typedef struct packed {
      logic        req;
      logic        wr;
      logic        wide;
      logic [21:0] addr;
      logic [31:0] wdata;
   } mmwc_req_t;

   typedef struct packed {
      logic [3:0] paged;
      logic [3:0] random;
      logic [3:0] otp;
   } mmwc_flwait_t;

   typedef enum logic [1:0] {
      MMWC_ST_IDLE  = 2'b00,
      MMWC_ST_ALIGN = 2'b01,
      MMWC_ST_WAIT  = 2'b10,
      MMWC_ST_DONE  = 2'b11
   } mmwc_state_t;
endpackage
`default_nettype wire

// file: mmwc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// memory and peripheral side: answers with a fixed word, ready on demand
module mmwc_mem_model #(
   parameter logic [31:0] DATA = 32'h1234_ABCD
) (
   input  wire logic        hold_i,   // bench asks for a ready stall
   output logic             ready_o,  // peripheral ready
   output logic [31:0]      rdata_o   // read data toward the decoder
);
   assign ready_o = !hold_i;
   // while stalled the data is not valid: show the inverse word
   assign rdata_o = hold_i ? ~DATA : DATA;
endmodule
`default_nettype wire

// file: memory_map_wait_state_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module memory_map_wait_state_control_tb_top;
   localparam logic [31:0] DATA = 32'h1234_ABCD;
   // narrow reads return the low half, zero-extended
   localparam logic [31:0] DATA_LO = {16'h0000, DATA[15:0]};
   localparam logic [15:0] PID  = 16'h1357; // arbitrary value
   localparam logic [15:0] CID  = 16'h2468; // arbitrary value
   localparam logic [15:0] RID  = 16'h0C0D; // arbitrary value
   localparam int          NROW = 22;
   typedef struct packed {
      logic        wr;
      logic [21:0] a;
      logic [4:0]  lat;
      logic [3:0]  rg;
      logic        blk;
      logic [1:0]  rd;
   } mmwc_row_t;
   logic                   sys_clk;
   logic                   reset_n;
   mmwc_pkg::mmwc_req_t    cpu_req;
   logic                   ready;
   logic [31:0]            mrd;
   logic                   unlock;
   logic                   lock;
   logic                   sec_ok;
   logic                   order_en;
   logic                   order_set;
   mmwc_pkg::mmwc_flwait_t flw;
   logic                   flw_wr;
   logic                   hold;
   logic                   done;
   logic [31:0]            rdata;
   mmwc_pkg::mmwc_req_t    mem;
   logic [3:0]             region;
   logic [2:0]             sector;
   logic                   blk_o;
   logic                   unlocked;
   logic [31:0]            lat;
   logic [31:0]            cap_rd;
   logic [3:0]             cap_rg;
   logic [2:0]             cap_sec;
   logic                   cap_blk;
   logic                   cap_mreq;
   logic                   cap_wide;
   int                     err_count;
   int                     samples_checked;
   mmwc_row_t              rows [NROW];
   logic [21:0]            id_a [3];
   logic [15:0]            id_v [3];
   logic [21:0]            sec_a [5];
   logic [2:0]             sec_v [5];

   mmwc_decoder #(.PART_ID(PID), .CLASS_ID(CID), .REV_ID(RID)) dut_u (
      .sys_clk_i(sys_clk), .reset_n_i(reset_n), .cpu_i(cpu_req),
      .periph_ready_i(ready), .mem_rdata_i(mrd), .unlock_i(unlock),
      .lock_i(lock), .sec_ok_i(sec_ok), .order_en_i(order_en),
      .order_set_i(order_set), .fl_wait_i(flw), .fl_wait_wr_i(flw_wr),
      .done_o(done), .rdata_o(rdata), .mem_o(mem), .region_o(region),
      .sector_o(sector), .wr_blocked_o(blk_o), .unlocked_o(unlocked));
   mmwc_mem_model #(.DATA(DATA)) mem_u (
      .hold_i(hold), .ready_o(ready), .rdata_o(mrd));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick;
      @(posedge sys_clk);
      #1;
   endtask

   // one access held until done, then the DONE gap before the next
   task automatic acc(input logic w, input logic wd, input logic [21:0] a);
      cpu_req = '{req: 1'b1, wr: w, wide: wd, addr: a, wdata: {10'h0, a}};
      // count from the taking edge to the edge that samples done high
      lat = 1;
      @(posedge sys_clk);
      do begin
         tick;
         lat++;
      end while (done !== 1'b1 && lat < 200);
      cap_rd = rdata;
      cap_rg = region;
      cap_sec = sector;
      cap_blk = blk_o;
      cap_mreq = mem.req;
      cap_wide = mem.wide;
      cpu_req.req = 1'b0;
      tick;
   endtask

   task automatic rd_lat(input logic [21:0] a, input logic [31:0] exp);
      acc(1'b0, 1'b0, a);
      chk(lat, exp);
   endtask

   task automatic wr_chk(input logic [21:0] a, input logic b);
      acc(1'b1, 1'b0, a);
      chk(32'(cap_blk), 32'(b));
      chk(32'(cap_mreq), 32'(!b));
      chk(32'(mem.addr), 32'(a));
   endtask

   task automatic prog(input logic [3:0] p, input logic [3:0] r,
                       input logic [3:0] o);
      flw = '{paged: p, random: r, otp: o};
      flw_wr = 1'b1;
      tick;
      flw_wr = 1'b0;
   endtask

   task automatic stall_acc(input logic w, input logic [21:0] a);
      hold = 1'b1;
      fork
         begin
            repeat (6) tick;
            hold = 1'b0;
         end
      join_none
      // let the stall pass the two ready flops before the access
      repeat (2) tick;
      acc(w, 1'b0, a);
      repeat (3) tick;
   endtask

   task automatic order(input logic v);
      order_set = v;
      order_en = 1'b1;
      tick;
      order_en = 1'b0;
   endtask

   initial begin
      #50000;
      err_count++;
      complete_run;
   end

   initial begin
      rows = '{
         '{1'b0, 22'h000100, 5'h02, mmwc_pkg::MMWC_RG_RAM, 1'b0, 2'h1},
         '{1'b0, 22'h001400, 5'h00, mmwc_pkg::MMWC_RG_RES, 1'b0, 2'h2},
         '{1'b0, 22'h007040, 5'h04, mmwc_pkg::MMWC_RG_F2, 1'b0, 2'h1},
         '{1'b1, 22'h007040, 5'h02, mmwc_pkg::MMWC_RG_F2, 1'b0, 2'h0},
         '{1'b0, 22'h007041, 5'h05, mmwc_pkg::MMWC_RG_F2, 1'b0, 2'h1},
         '{1'b1, 22'h006F80, 5'h02, mmwc_pkg::MMWC_RG_F1, 1'b0, 2'h0},
         '{1'b1, 22'h006F81, 5'h03, mmwc_pkg::MMWC_RG_F1, 1'b0, 2'h0},
         '{1'b0, 22'h006F80, 5'h05, mmwc_pkg::MMWC_RG_F1, 1'b0, 2'h1},
         '{1'b0, 22'h005000, 5'h04, mmwc_pkg::MMWC_RG_F3, 1'b0, 2'h1},
         '{1'b0, 22'h3F8000, 5'h02, mmwc_pkg::MMWC_RG_ROM, 1'b0, 2'h1},
         '{1'b0, 22'h3F7FF8, 5'h12, mmwc_pkg::MMWC_RG_PWD, 1'b0, 2'h0},
         '{1'b0, 22'h3D8000, 5'h11, mmwc_pkg::MMWC_RG_FLASH, 1'b0, 2'h0},
         '{1'b1, 22'h000A80, 5'h00, mmwc_pkg::MMWC_RG_F0, 1'b1, 2'h0},
         '{1'b1, 22'h007010, 5'h00, mmwc_pkg::MMWC_RG_F2, 1'b1, 2'h0},
         '{1'b1, 22'h000B00, 5'h00, mmwc_pkg::MMWC_RG_F0, 1'b1, 2'h0},
         '{1'b1, 22'h000C00, 5'h02, mmwc_pkg::MMWC_RG_F0, 1'b0, 2'h0},
         '{1'b1, 22'h000880, 5'h00, 4'hF, 1'b1, 2'h0},
         '{1'b1, 22'h001400, 5'h00, mmwc_pkg::MMWC_RG_RES, 1'b1, 2'h0},
         '{1'b0, 22'h000B00, 5'h02, mmwc_pkg::MMWC_RG_F0, 1'b0, 2'h1},
         '{1'b0, 22'h3D7800, 5'h11, mmwc_pkg::MMWC_RG_OTP, 1'b0, 2'h0},
         '{1'b1, 22'h000882, 5'h00, 4'hF, 1'b1, 2'h0},
         '{1'b0, 22'h000C00, 5'h02, mmwc_pkg::MMWC_RG_F0, 1'b0, 2'h1}};
      id_a = '{22'h000882, 22'h000883, 22'h3D7E80};
      id_v = '{CID, RID, PID};
      sec_a = '{22'h3DBFFF, 22'h3DC000, 22'h3F0000, 22'h3F7FF5, 22'h3F7FF6};
      sec_v = '{3'h0, 3'h1, 3'h6, 3'h7, 3'h7};
      err_count = 0;
      samples_checked = 0;
      reset_n = 1'b0;
      cpu_req = '0;
      {unlock, lock, sec_ok, order_en, order_set, flw_wr, hold} = 7'h00;
      flw = '0;
      repeat (3) @(posedge sys_clk);
      #1;
      reset_n = 1'b1;
      chk(32'(unlocked), 32'h0);
      for (int i = 0; i < NROW; i++) begin
         acc(rows[i].wr, 1'b0, rows[i].a);
         if (rows[i].lat != 5'h00) chk(lat, 32'(rows[i].lat));
         if (rows[i].rg != 4'hF) chk(32'(cap_rg), 32'(rows[i].rg));
         if (rows[i].wr) begin
            chk(32'(cap_blk), 32'(rows[i].blk));
            chk(32'(cap_mreq), 32'(!rows[i].blk));
         end else if (rows[i].rd != 2'h0) begin
            chk(cap_rd, rows[i].rd == 2'h1 ? DATA_LO : 32'h0);
         end
      end
      for (int i = 0; i < 3; i++) begin
         acc(1'b0, 1'b0, id_a[i]);
         chk(cap_rd, {16'h0, id_v[i]});
      end
      for (int i = 0; i < 5; i++) begin
         acc(1'b0, 1'b0, sec_a[i]);
         chk(32'(cap_sec), 32'(sec_v[i]));
         chk(32'(cap_rg), 32'(mmwc_pkg::MMWC_RG_FLASH));
      end
      prog(4'h0, 4'h1, 4'h1);
      rd_lat(22'h3D9000, 32'd17);
      unlock = 1'b1;
      tick;
      unlock = 1'b0;
      chk(32'(unlocked), 32'h1);
      prog(4'h0, 4'h1, 4'h1);
      rd_lat(22'h3DA000, 32'd17);
      sec_ok = 1'b1;
      prog(4'h3, 4'h5, 4'h2);
      rd_lat(22'h3D8100, 32'd7);
      rd_lat(22'h3D8101, 32'd5);
      rd_lat(22'h3D7800, 32'd4);
      rd_lat(22'h3F7FFA, 32'd18);
      prog(4'h6, 4'h2, 4'h0);
      rd_lat(22'h3D8200, 32'd8);
      rd_lat(22'h3D8201, 32'd8);
      rd_lat(22'h3D7801, 32'd3);
      wr_chk(22'h007010, 1'b0);
      wr_chk(22'h001000, 1'b0);
      sec_ok = 1'b0;
      wr_chk(22'h000A80, 1'b1);
      sec_ok = 1'b1;
      wr_chk(22'h000A80, 1'b0);
      lock = 1'b1;
      tick;
      lock = 1'b0;
      chk(32'(unlocked), 32'h0);
      wr_chk(22'h000880, 1'b1);
      acc(1'b1, 1'b1, 22'h000C00);
      chk(32'(cap_wide), 32'h1);
      chk(32'(cap_mreq), 32'h1);
      order(1'b0);
      acc(1'b1, 1'b0, 22'h007040);
      rd_lat(22'h007041, 32'd4);
      order(1'b1);
      acc(1'b1, 1'b0, 22'h006F90);
      rd_lat(22'h007042, 32'd5);
      stall_acc(1'b0, 22'h006F80);
      chk(32'(lat > 4), 32'h1);
      stall_acc(1'b0, 22'h007040);
      chk(lat, 32'd4);
      stall_acc(1'b1, 22'h005000);
      chk(32'(lat > 2), 32'h1);
      unlock = 1'b1;
      tick;
      unlock = 1'b0;
      reset_n = 1'b0;
      tick;
      chk(32'(unlocked), 32'h0);
      chk(32'(done), 32'h0);
      reset_n = 1'b1;
      rd_lat(22'h3D9000, 32'd17);
      acc(1'b1, 1'b0, 22'h007040);
      rd_lat(22'h007041, 32'd5);
      complete_run;
   end
endmodule
`default_nettype wire
